// *** design/tcb_pkg.sv ***
// constants for the 8-bit timer/counter with event input, buzzer and pwm
// assumes a 32-bit apb slave, each register on one aligned word at four times its index
package tcb_pkg;
  // ****************************************
  // bus geometry
  // ****************************************
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int REG_W = 8;

  // ****************************************
  // register indices and byte addresses
  // ****************************************
  localparam logic [APB_AW-1:0] IDX_RELOAD = 12'h0cd;
  localparam logic [APB_AW-1:0] IDX_BASIC_MODE = 12'h0d8;
  localparam logic [APB_AW-1:0] IDX_MODE = 12'h0da;
  localparam logic [APB_AW-1:0] IDX_COUNT = 12'h0db;
  localparam logic [APB_AW-1:0] IDX_STATUS = 12'h0e0;
  localparam logic [APB_AW-1:0] ADDR_RELOAD = IDX_RELOAD << 2;
  localparam logic [APB_AW-1:0] ADDR_BASIC_MODE = IDX_BASIC_MODE << 2;
  localparam logic [APB_AW-1:0] ADDR_MODE = IDX_MODE << 2;
  localparam logic [APB_AW-1:0] ADDR_COUNT = IDX_COUNT << 2;
  localparam logic [APB_AW-1:0] ADDR_STATUS = IDX_STATUS << 2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int MODE_PWM_BIT = 0;
  localparam int MODE_TOGGLE_BIT = 1;
  localparam int MODE_ALOAD_BIT = 2;
  localparam int MODE_EXT_BIT = 3;
  localparam int MODE_RATE_LSB = 4;
  localparam int MODE_RATE_W = 3;
  localparam int MODE_EN_BIT = 7;
  localparam int BASIC_SRC_BIT = 1;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_IEN_BIT = 1;
  localparam int STAT_EXT_FLAG_BIT = 2;

  // ****************************************
  // reset values and boundaries
  // ****************************************
  localparam logic [REG_W-1:0] RST_BYTE = 8'h00;
  localparam logic [REG_W-1:0] MASK_256 = 8'hff;
  localparam logic [REG_W-1:0] MASK_64 = 8'h3f;
  localparam logic [REG_W-1:0] MASK_32 = 8'h1f;
  localparam logic [REG_W-1:0] MASK_16 = 8'h0f;
  localparam logic [REG_W-1:0] FCPU_MAX_MASK = 8'hff;
  localparam logic [REG_W-1:0] FHOSC_MAX_MASK = 8'h7f;
  localparam logic [APB_DW-1:0] RD_ZERO = 32'h0000_0000;
endpackage : tcb_pkg

// *** design/tcb_sync2.sv ***
// two-flop level synchroniser for a pin entering the pclk domain
// assumes the input is asynchronous and may change at any time
`timescale 1ns/1ps
module tcb_sync2
  #(
    parameter logic RST_VAL = 1'b1
  )
  (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
  );
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // first flop feeds only the second one
  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : tcb_sync2

// *** design/tcb_timer.sv ***
// 8-bit up timer/counter with prescaler, event counter, buzzer and pwm, apb registers
// assumes fcpu_tick and fhosc_tick are one-cycle pclk pulses; pins arrive asynchronous
// Functional notes
// - counter advances only while the run enable bit is one
// - pwm enable bit hands the shared pin to the pwm waveform
// - toggle bit without pwm puts a half-overflow-rate square wave on the pin
// - bit 2 enables auto-reload outside pwm, selects resolution inside pwm when event mode is off
// - event mode bit one counts the event pin and ignores the rate field
// - instruction clock divided by 256 for code 0 down to 2 for code 7
// - high oscillator divided by 128 for code 0 down to 1 for code 7
// - shared basic mode bit 1 picks instruction clock or high oscillator
// - counter steps once per tick; overflow sets a sticky flag cleared by software
// - overflow reloads the counter from the holding buffer without software when auto-reload or pwm is on
// - boundary 256, or 256/64/32/16 by resolution code in pwm mode with event mode off
// - reload writes land in a holding buffer, moved over at overflow
// - event mode counts falling edges of the event pin, overflow at ff to 00 or, with auto-reload, to the reload value
// - event mode suppresses wake-up from the event pin
// - buzzer overrides the pin and toggles it at every overflow
// - pwm cycle starts high, goes low at compare, high again at overflow
// - pwm duty changes take effect from the next reload; resolution code changes take effect at once
// - overflow flag and interrupt request continue in pwm mode
// - clearing both pwm enable and toggle bit returns the pin to its gpio function at once
// - green mode keeps everything running but blocks the timer wake request; ext_pin_wake_out still follows the pin
`timescale 1ns/1ps
module tcb_timer
  (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcb_pkg::APB_AW-1:0] paddr,
    input wire logic [tcb_pkg::APB_DW-1:0] pwdata,
    output logic [tcb_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fcpu_tick,
    input wire logic fhosc_tick,
    input wire logic event_input_pin,
    input wire logic ext_interrupt_input,
    input wire logic ext_pin_wake_in,
    input wire logic green_mode,
    output logic shared_wave_pin,
    output logic shared_wave_override,
    output logic overflow_irq_req,
    output logic tc0_wake_req,
    output logic ext_pin_wake_out
  );
  import tcb_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [REG_W-1:0] mode_reg, mode_next;
  logic basic_src_reg, basic_src_next;
  logic [REG_W-1:0] count_reg, count_next;
  logic [REG_W-1:0] hold_reg, hold_next;
  logic [REG_W-1:0] reload_reg, reload_next;
  logic [REG_W-1:0] pre_reg, pre_next;
  logic ovf_flag_reg, ovf_flag_next;
  logic ien_reg, ien_next;
  logic ext_flag_reg, ext_flag_next;
  logic pwm_level_reg, pwm_level_next;
  logic buzz_reg, buzz_next;
  logic pin_reg, pin_next;
  logic override_reg, override_next;
  logic irq_reg, irq_next;
  logic wake_reg, wake_next;
  logic pwake_reg, pwake_next;
  logic evt_prev_reg, evt_prev_next;
  logic [APB_DW-1:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  logic evt_sync;
  logic en, pwm_on, toggle_on, aload_on, ext_on;
  logic [MODE_RATE_W-1:0] rate;
  logic [REG_W-1:0] bound;
  logic [REG_W-1:0] div_mask;
  logic src_tick, tick, ovf, evt_fall;
  logic setup, acc_wr, mapped;
  logic wr_mode, wr_basic, wr_count, wr_reload, wr_status;

  // ****************************************
  // event pin synchroniser
  // ****************************************
  tcb_sync2 #(
    .RST_VAL(1'b1)
  ) u_evt_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(event_input_pin),
    .sync_out(evt_sync)
  );

  // ****************************************
  // decode of mode and tick generation
  // ****************************************
  always_comb
  begin
    en = mode_reg[MODE_EN_BIT];
    pwm_on = mode_reg[MODE_PWM_BIT];
    toggle_on = mode_reg[MODE_TOGGLE_BIT] & ~pwm_on;
    aload_on = mode_reg[MODE_ALOAD_BIT] & ~pwm_on;
    ext_on = mode_reg[MODE_EXT_BIT];
    rate = mode_reg[MODE_RATE_LSB +: MODE_RATE_W];
    // resolution only narrows the count inside pwm; event mode always spans 256
    bound = MASK_256;
    if (pwm_on && !ext_on)
    begin
      case ({mode_reg[MODE_ALOAD_BIT], mode_reg[MODE_TOGGLE_BIT]})
        2'b01: bound = MASK_64;
        2'b10: bound = MASK_32;
        2'b11: bound = MASK_16;
        default: bound = MASK_256;
      endcase
    end
    // code steps halve the division: mask of the prescaler low bits
    if (basic_src_reg)
    begin
      div_mask = FHOSC_MAX_MASK >> rate;
      src_tick = fhosc_tick;
    end
    else
    begin
      div_mask = FCPU_MAX_MASK >> rate;
      src_tick = fcpu_tick;
    end
    evt_fall = evt_prev_reg & ~evt_sync;
    if (ext_on)
    begin
      tick = en & evt_fall;
    end
    else
    begin
      tick = en & src_tick & ((pre_reg & div_mask) == div_mask);
    end
    ovf = tick & ((count_reg & bound) == bound);
  end

  // ****************************************
  // apb decode
  // ****************************************
  always_comb
  begin
    setup = psel & ~penable;
    acc_wr = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    mapped = (paddr == ADDR_RELOAD) || (paddr == ADDR_BASIC_MODE) ||
      (paddr == ADDR_MODE) || (paddr == ADDR_COUNT) || (paddr == ADDR_STATUS);
    wr_mode = acc_wr & (paddr == ADDR_MODE);
    wr_basic = acc_wr & (paddr == ADDR_BASIC_MODE);
    wr_count = acc_wr & (paddr == ADDR_COUNT);
    wr_reload = acc_wr & (paddr == ADDR_RELOAD);
    wr_status = acc_wr & (paddr == ADDR_STATUS);
    pready_next = setup;
    pslverr_next = setup & ~mapped;
    prdata_next = RD_ZERO;
    if (setup)
    begin
      case (paddr)
        ADDR_MODE: prdata_next = {24'h00_0000, mode_reg};
        ADDR_BASIC_MODE: prdata_next = {30'h000_0000, basic_src_reg, 1'b0};
        ADDR_COUNT: prdata_next = {24'h00_0000, count_reg};
        ADDR_STATUS: prdata_next = {29'h000_0000, ext_flag_reg, ien_reg, ovf_flag_reg};
        default: prdata_next = RD_ZERO;
      endcase
    end
  end

  // ****************************************
  // timer next state
  // ****************************************
  always_comb
  begin
    mode_next = wr_mode ? pwdata[REG_W-1:0] : mode_reg;
    basic_src_next = wr_basic ? pwdata[BASIC_SRC_BIT] : basic_src_reg;
    ien_next = wr_status ? pwdata[STAT_IEN_BIT] : ien_reg;
    hold_next = wr_reload ? pwdata[REG_W-1:0] : hold_reg;
    // buffer moves at overflow; while stopped it follows so the first cycle is right
    reload_next = reload_reg;
    if (ovf || !en)
    begin
      reload_next = hold_reg;
    end
    pre_next = (src_tick && en && !ext_on) ? pre_reg + 8'h01 : pre_reg;
    count_next = count_reg;
    if (wr_count)
    begin
      count_next = pwdata[REG_W-1:0];
    end
    else if (ovf)
    begin
      // plain timer without auto-reload wraps to zero
      count_next = (pwm_on || aload_on) ? (hold_reg & bound) : RST_BYTE;
    end
    else if (tick)
    begin
      count_next = count_reg + 8'h01;
    end
    // hardware set wins over a software write-one clear
    ovf_flag_next = ovf | (ovf_flag_reg & ~(wr_status & pwdata[STAT_OVF_BIT]));
    if (ext_on)
    begin
      ext_flag_next = 1'b0;
    end
    else
    begin
      ext_flag_next = ext_interrupt_input |
        (ext_flag_reg & ~(wr_status & pwdata[STAT_EXT_FLAG_BIT]));
    end
    pwm_level_next = pwm_level_reg;
    if (ovf || !en)
    begin
      pwm_level_next = 1'b1;
    end
    else if (count_reg == (reload_reg & bound))
    begin
      pwm_level_next = 1'b0;
    end
    buzz_next = ovf ? ~buzz_reg : buzz_reg;
    override_next = mode_next[MODE_PWM_BIT] | mode_next[MODE_TOGGLE_BIT];
    if (pwm_on)
    begin
      pin_next = pwm_level_next;
    end
    else if (toggle_on)
    begin
      pin_next = buzz_next;
    end
    else
    begin
      pin_next = 1'b0;
    end
    irq_next = ovf_flag_next & ien_next;
    wake_next = ovf_flag_next & ien_next & ~green_mode;
    pwake_next = ext_pin_wake_in & ~ext_on;
    evt_prev_next = evt_sync;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= RST_BYTE;
      basic_src_reg <= 1'b0;
      count_reg <= RST_BYTE;
      hold_reg <= RST_BYTE;
      reload_reg <= RST_BYTE;
      pre_reg <= RST_BYTE;
      ovf_flag_reg <= 1'b0;
      ien_reg <= 1'b0;
      ext_flag_reg <= 1'b0;
      pwm_level_reg <= 1'b1;
      buzz_reg <= 1'b0;
      pin_reg <= 1'b0;
      override_reg <= 1'b0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      pwake_reg <= 1'b0;
      evt_prev_reg <= 1'b1;
      prdata_reg <= RD_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      basic_src_reg <= basic_src_next;
      count_reg <= count_next;
      hold_reg <= hold_next;
      reload_reg <= reload_next;
      pre_reg <= pre_next;
      ovf_flag_reg <= ovf_flag_next;
      ien_reg <= ien_next;
      ext_flag_reg <= ext_flag_next;
      pwm_level_reg <= pwm_level_next;
      buzz_reg <= buzz_next;
      pin_reg <= pin_next;
      override_reg <= override_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
      pwake_reg <= pwake_next;
      evt_prev_reg <= evt_prev_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign shared_wave_pin = pin_reg;
  assign shared_wave_override = override_reg;
  assign overflow_irq_req = irq_reg;
  assign tc0_wake_req = wake_reg;
  assign ext_pin_wake_out = pwake_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_stopped_count_hold: assert property (
    (!en && !wr_count) |=> (count_reg == $past(count_reg)))
    else $error("counter moved while disabled");

  a_pwm_pin_owner: assert property (
    (pwm_on && !wr_mode) |=> (override_reg && (pin_reg == pwm_level_reg)))
    else $error("pin not carrying pwm");

  a_buzz_toggle: assert property (
    (ovf && toggle_on && !wr_mode) |=> (pin_reg != $past(pin_reg)))
    else $error("buzzer pin did not toggle at overflow");

  a_ovf_flag_set: assert property (
    ovf |=> ovf_flag_reg ##1 (ovf_flag_reg || $past(wr_status)))
    else $error("overflow flag not held");

  a_reload_on_ovf: assert property (
    (ovf && (pwm_on || aload_on) && !wr_count) |=>
      (count_reg == ($past(hold_reg) & $past(bound))))
    else $error("counter not reloaded at overflow");

  a_hold_buffer: assert property (
    (en && !ovf) |=> (reload_reg == $past(reload_reg)))
    else $error("active reload changed between overflows");

  a_pwm_start_high: assert property (
    (ovf && pwm_on) |=> pwm_level_reg)
    else $error("pwm cycle did not start high");

  a_ext_flag_zero: assert property (
    ext_on |=> !ext_flag_reg)
    else $error("pin interrupt flag set in event mode");

  a_event_wake_mask: assert property (
    ext_on |=> !pwake_reg)
    else $error("event pin woke the system");

  a_green_no_wake: assert property (
    green_mode |=> !wake_reg)
    else $error("timer woke the system in green mode");

  a_event_edge_count: assert property (
    (en && ext_on && evt_fall && !ovf && !wr_count) |=>
      (count_reg == $past(count_reg) + 8'h01))
    else $error("falling edge not counted");
endmodule : tcb_timer

// *** test/tc0_timer_pwm_buzzer_tb_top.sv ***
// self-checking bench for the timer/counter with event input, buzzer and pwm
// assumes tcb_pkg, tcb_timer and tcb_evt_src are compiled first
`timescale 1ns/1ps
module tc0_timer_pwm_buzzer_tb_top;
  import tcb_pkg::*;
  localparam logic [31:0] RUN = 32'h0000_0080;
  localparam logic [31:0] EXT = 32'h0000_0008;
  localparam logic [31:0] ALD = 32'h0000_0004;
  localparam logic [31:0] TOG = 32'h0000_0002;
  localparam logic [31:0] PWM = 32'h0000_0001;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdata;
  logic pready, pslverr, rerr, fcpu_tick = 1'b0, fhosc_tick = 1'b0, event_input_pin;
  logic ext_interrupt_input = 1'b0, ext_pin_wake_in = 1'b0, green_mode = 1'b0;
  logic shared_wave_pin, shared_wave_override, overflow_irq_req, tc0_wake_req;
  logic ext_pin_wake_out, pin_prev = 1'b0;
  int errors = 0, checks_done = 0, rises = 0;
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    pin_prev <= shared_wave_pin;
    if (shared_wave_pin === 1'b1 && pin_prev === 1'b0) rises <= rises + 1;
  end
  tcb_evt_src i_src (.event_input_pin(event_input_pin));
  tcb_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fcpu_tick(fcpu_tick), .fhosc_tick(fhosc_tick),
    .event_input_pin(event_input_pin), .ext_interrupt_input(ext_interrupt_input),
    .ext_pin_wake_in(ext_pin_wake_in), .green_mode(green_mode),
    .shared_wave_pin(shared_wave_pin), .shared_wave_override(shared_wave_override),
    .overflow_irq_req(overflow_irq_req), .tc0_wake_req(tc0_wake_req),
    .ext_pin_wake_out(ext_pin_wake_out));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one source pulse every second cycle, then let the registered outputs settle
  task automatic tick(input int n, input logic hosc);
    repeat (n)
    begin
      @(posedge pclk);
      if (hosc) fhosc_tick <= 1'b1;
      else fcpu_tick <= 1'b1;
      @(posedge pclk);
      fhosc_tick <= 1'b0;
      fcpu_tick <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask : tick
  task automatic setup(input logic [31:0] mode, input logic [31:0] start, input logic src);
    apb(1, ADDR_MODE, 32'h0000_0000);
    apb(1, ADDR_BASIC_MODE, {30'd0, src, 1'b0});
    apb(1, ADDR_COUNT, start);
    apb(1, ADDR_RELOAD, start);
    apb(1, ADDR_MODE, mode);
    apb(1, ADDR_MODE, mode | RUN);
  endtask : setup
  task automatic final_report;
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    apb(0, ADDR_MODE, 0);
    chk("mode reset", rdata, 32'h0000_0000);
    apb(0, ADDR_COUNT, 0);
    chk("count reset", rdata, 32'h0000_0000);
    apb(0, ADDR_RELOAD, 0);
    chk("reload reads zero", rdata, 32'h0000_0000);
    apb(1, ADDR_MODE, 32'h0000_005a);
    apb(0, ADDR_MODE, 0);
    chk("mode readback", rdata, 32'h0000_005a);
    apb(0, 12'h004, 0);
    chk("unmapped error", {31'd0, rerr}, 32'h0000_0001);
  endtask : t_regs
  task automatic t_rates;
    for (int k = 0; k < 8; k++)
      for (int s = 0; s < 2; s++)
      begin
        setup(ALD | (k << 4), 32'h0000_0010, s[0]);
        tick(2 * (s ? (128 >> k) : (256 >> k)), s[0]);
        apb(0, ADDR_COUNT, 0);
        chk("rate count", rdata, 32'h0000_0012);
      end
    apb(1, ADDR_MODE, 32'h0000_0070);
    tick(4, 1'b1);
    apb(0, ADDR_COUNT, 0);
    chk("stopped count", rdata, 32'h0000_0012);
  endtask : t_rates
  task automatic t_overflow;
    apb(1, ADDR_STATUS, 32'h0000_0003);
    setup(ALD | 32'h0000_0070, 32'h0000_00fe, 1'b0);
    apb(1, ADDR_RELOAD, 32'h0000_0010);
    tick(4, 1'b0);
    apb(0, ADDR_COUNT, 0);
    chk("reload at overflow", rdata, 32'h0000_0010);
    apb(0, ADDR_STATUS, 0);
    chk("flag set", rdata, 32'h0000_0003);
    chk("irq", overflow_irq_req, 1);
    chk("wake", tc0_wake_req, 1);
    green_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("green no wake", tc0_wake_req, 0);
    apb(1, ADDR_RELOAD, 32'h0000_0040);
    tick(2, 1'b0);
    apb(0, ADDR_COUNT, 0);
    chk("buffer held", rdata, 32'h0000_0011);
    tick(2 * 32'h00ef, 1'b0);
    apb(0, ADDR_COUNT, 0);
    chk("buffer moved", rdata, 32'h0000_0040);
    apb(1, ADDR_STATUS, 32'h0000_0003);
    apb(0, ADDR_STATUS, 0);
    chk("flag cleared", rdata, 32'h0000_0002);
    chk("irq cleared", overflow_irq_req, 0);
    green_mode <= 1'b0;
  endtask : t_overflow
  task automatic t_event;
    apb(1, ADDR_STATUS, 32'h0000_0005);
    ext_pin_wake_in <= 1'b1;
    setup(EXT | ALD | 32'h0000_0070, 32'h0000_00fe, 1'b0);
    tick(8, 1'b0);
    chk("no wake", ext_pin_wake_out, 0);
    @(posedge pclk) ext_interrupt_input <= 1'b1;
    @(posedge pclk) ext_interrupt_input <= 1'b0;
    apb(0, ADDR_COUNT, 0);
    chk("rate ignored", rdata, 32'h0000_00fe);
    i_src.edges(3, 200);
    repeat (8) @(posedge pclk);
    apb(0, ADDR_COUNT, 0);
    chk("event count", rdata, 32'h0000_00ff);
    apb(0, ADDR_STATUS, 0);
    chk("pin flag held", rdata, 32'h0000_0001);
    apb(1, ADDR_MODE, RUN);
    repeat (3) @(posedge pclk);
    chk("wake back", ext_pin_wake_out, 1);
    @(posedge pclk) ext_interrupt_input <= 1'b1;
    @(posedge pclk) ext_interrupt_input <= 1'b0;
    apb(0, ADDR_STATUS, 0);
    chk("pin flag", rdata, 32'h0000_0005);
    ext_pin_wake_in <= 1'b0;
  endtask : t_event
  task automatic t_buzzer;
    logic p0;
    setup(TOG | ALD | 32'h0000_0070, 32'h0000_00ff, 1'b0);
    chk("buzzer override", shared_wave_override, 1);
    p0 = shared_wave_pin;
    tick(2, 1'b0);
    chk("toggle one", shared_wave_pin, {31'd0, ~p0});
    tick(2, 1'b0);
    chk("toggle two", shared_wave_pin, p0);
    // without auto-reload the counter simply wraps to zero
    apb(1, ADDR_MODE, RUN | TOG | 32'h0000_0070);
    apb(1, ADDR_COUNT, 32'h0000_00ff);
    tick(2, 1'b0);
    apb(0, ADDR_COUNT, 0);
    chk("no reload wraps", rdata, 32'h0000_0000);
  endtask : t_buzzer
  task automatic t_pwm;
    int r0;
    apb(1, ADDR_STATUS, 32'h0000_0001);
    // duty must sit in the reload before run, a later write waits for overflow
    apb(1, ADDR_MODE, 32'h0000_0000);
    apb(1, ADDR_COUNT, 32'h0000_0000);
    apb(1, ADDR_RELOAD, 32'h0000_0003);
    apb(1, ADDR_MODE, PWM | TOG | 32'h0000_0070);
    apb(1, ADDR_MODE, RUN | PWM | TOG | 32'h0000_0070);
    tick(4, 1'b0);
    chk("pwm high", shared_wave_pin, 1);
    tick(2, 1'b0);
    chk("pwm low", shared_wave_pin, 0);
    apb(1, ADDR_RELOAD, 32'h0000_0005);
    tick(2 * 32'h003c, 1'b0);
    apb(0, ADDR_COUNT, 0);
    chk("pwm bound", rdata, 32'h0000_003f);
    r0 = rises;
    tick(2, 1'b0);
    chk("pwm rise", rises - r0, 1);
    apb(0, ADDR_COUNT, 0);
    chk("next cycle duty", rdata, 32'h0000_0005);
    apb(0, ADDR_STATUS, 0);
    chk("pwm flag", rdata[0], 1);
    apb(1, ADDR_MODE, RUN | TOG | 32'h0000_0070);
    apb(1, ADDR_MODE, RUN | 32'h0000_0070);
    @(posedge pclk);
    chk("gpio back", shared_wave_override, 0);
  endtask : t_pwm
  initial
  begin
    #2_000_000;
    errors++;
    final_report();
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rates();
    t_overflow();
    t_event();
    t_buzzer();
    t_pwm();
    final_report();
  end
endmodule : tc0_timer_pwm_buzzer_tb_top

// *** test/tcb_evt_src.sv ***
// far-side model: the source of events on the timer's event pin
// assumes the pin has a pull-up, so it idles high between pulses
`timescale 1ns/1ps
module tcb_evt_src
  (
    output logic event_input_pin
  );
  initial event_input_pin = 1'b1;
  // edges land off the pclk grid on purpose, the pin is asynchronous
  task automatic edges(input int n, input int half_ns);
    repeat (n)
    begin
      #(half_ns + 3) event_input_pin = 1'b0;
      #(half_ns) event_input_pin = 1'b1;
    end
  endtask : edges
endmodule : tcb_evt_src
